// [core/fcavp_pkg.sv]
package fcavp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned RATE_HI_HZ = 8000;
  localparam int unsigned RATE_LO_HZ = 6400;
  localparam int unsigned PER_HI_CYC = CLK_HZ / RATE_HI_HZ;
  localparam int unsigned PER_LO_CYC = CLK_HZ / RATE_LO_HZ;
  localparam int unsigned CLK_PS = 8000;
  localparam int unsigned ROM_ACC_NS = 100;
  // access time rounded up, plus two cycles for the data synchroniser
  localparam logic [4:0] ROM_WAIT =
    5'((ROM_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS + 2);

  // ----------------------------------------------------------------
  // layout and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] TBL_LAST = 3'h5;
  localparam logic [2:0] TBL_STOP = 3'h3;
  localparam logic [5:0] IDX_MAX = 6'h30;
  localparam logic [11:0] VOICE_MID = 12'h800;
  localparam logic [12:0] PIN_RV = 13'h0700;
  localparam int PIN_RSTN = 12;
  localparam int PIN_RATE = 11;
  localparam int PIN_CS = 10;
  localparam int PIN_WR = 9;
  localparam int PIN_RD = 8;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_CHAN = 3'h1,
    S_RD = 3'h3,
    S_DEC = 3'h2,
    S_MIX = 3'h6
  } fcavp_state_t;

  // gain in 1/256 for each attenuation code
  function automatic logic [8:0] fcavp_gain(input logic [3:0] a);
    unique case (a)
      4'h0: fcavp_gain = 9'h100;
      4'h1: fcavp_gain = 9'h0B1;
      4'h2: fcavp_gain = 9'h080;
      4'h3: fcavp_gain = 9'h059;
      4'h4: fcavp_gain = 9'h040;
      4'h5: fcavp_gain = 9'h030;
      4'h6: fcavp_gain = 9'h020;
      4'h7: fcavp_gain = 9'h018;
      default: fcavp_gain = 9'h010;
    endcase
  endfunction

endpackage

// [core/fcavp_sync.sv]
`timescale 1ns/100ps
module fcavp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RV = '0
) (
  // clock
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= RV;
      q_o <= RV;
    end else if (ce_i) begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end

endmodule

// [core/fcavp_adpcm.sv]
`timescale 1ns/100ps
module fcavp_adpcm (
  // predictor state
  input wire logic signed [11:0] pred_i,
  input wire logic [5:0] idx_i,
  input wire logic [3:0] nib_i,
  // next state
  output logic signed [11:0] pred_o,
  output logic [5:0] idx_o
);

  // step roughly 1.09x per index, 16 .. 1024
  wire [10:0] step_w = 11'({1'b1, idx_i[2:0], 1'b0}) << idx_i[5:3];
  wire [12:0] diff_w = 13'(step_w >> 3)
    + (nib_i[0] ? 13'(step_w >> 2) : 13'h0000)
    + (nib_i[1] ? 13'(step_w >> 1) : 13'h0000)
    + (nib_i[2] ? 13'(step_w) : 13'h0000);
  wire signed [13:0] sum_w = nib_i[3]
    ? 14'(pred_i) - 14'(signed'({1'b0, diff_w}))
    : 14'(pred_i) + 14'(signed'({1'b0, diff_w}));
  wire signed [6:0] adj_w = nib_i[2]
    ? 7'(signed'({3'h0, nib_i[1:0], 1'b0}) + 7'sh02) : -7'sh01;
  wire signed [6:0] ni_w = signed'({1'b0, idx_i}) + adj_w;

  assign pred_o = (sum_w > 14'sh07FF) ? 12'sh7FF
    : (sum_w < -14'sh0800) ? -12'sh800 : sum_w[11:0];
  assign idx_o = ni_w[6] ? 6'h00
    : (ni_w[5:0] > fcavp_pkg::IDX_MAX) ? fcavp_pkg::IDX_MAX : ni_w[5:0];

endmodule

// [core/fcavp_top.sv]
`timescale 1ns/100ps
module fcavp_top #(
  parameter int unsigned PER_HI = fcavp_pkg::PER_HI_CYC,
  parameter int unsigned PER_LO = fcavp_pkg::PER_LO_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // device pins
  input wire logic reset_n_i,
  input wire logic rate_sel_i,
  // host command bus
  input wire logic cs_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // sample rom
  output logic [17:0] rom_addr_o,
  input wire logic [7:0] rom_data_i,
  // converter code
  output logic [11:0] voice_out_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [12:0] pin_s;
  logic [7:0] rom_s;

  fcavp_sync #(.W(13), .RV(fcavp_pkg::PIN_RV)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({reset_n_i, rate_sel_i, cs_n_i, wr_n_i, rd_n_i, data_i}),
    .q_o(pin_s)
  );

  fcavp_sync #(.W(8)) u_rom_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(rom_data_i),
    .q_o(rom_s)
  );

  wire hold_w = ~pin_s[fcavp_pkg::PIN_RSTN];
  wire [7:0] d_w = pin_s[7:0];

  // ----------------------------------------------------------------
  // command capture
  // ----------------------------------------------------------------
  logic wr_d_ff;
  logic first_ff;
  logic [6:0] ptmp_ff;
  logic [6:0] phr_ff [4];
  logic [3:0] att_ff [4];
  logic [3:0] busy_ff;
  logic [3:0] ld_ff;

  // cs must still be low in the same sampled cycle as the rise
  wire wr_rise_w = pin_s[fcavp_pkg::PIN_WR] & ~wr_d_ff
    & ~pin_s[fcavp_pkg::PIN_CS];
  wire first_w = wr_rise_w & ~first_ff & d_w[7];
  wire second_w = wr_rise_w & first_ff;
  wire [3:0] sel_w = d_w[7:4];
  wire onehot_w = (sel_w != 4'h0) && ((sel_w & (sel_w - 4'h1)) == 4'h0);
  // phrase zero has no table entry, so it is dropped
  wire start_w = second_w & (ptmp_ff != 7'h00) & onehot_w;
  wire stop_w = wr_rise_w & ~first_ff & ~d_w[7];
  wire [3:0] kill_w = stop_w ? d_w[6:3] : 4'h0;
  wire [3:0] set_w = start_w ? sel_w : 4'h0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_d_ff <= 1'b1;
      first_ff <= 1'b0;
      ptmp_ff <= 7'h00;
    end else if (ce_i) begin
      wr_d_ff <= hold_w | pin_s[fcavp_pkg::PIN_WR];
      if (hold_w) begin
        first_ff <= 1'b0;
      end else if (first_w) begin
        first_ff <= 1'b1;
        ptmp_ff <= d_w[6:0];
      end else if (second_w) begin
        first_ff <= 1'b0;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cfg
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          phr_ff[g] <= 7'h00;
          att_ff[g] <= 4'h0;
        end else if (ce_i && !hold_w && set_w[g]) begin
          phr_ff[g] <= ptmp_ff;
          att_ff[g] <= d_w[3:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // busy and table-loaded flags
  // ----------------------------------------------------------------
  logic [3:0] done_w;
  logic [3:0] ldset_w;
  // a new start wins over the end of the previous phrase
  wire [3:0] nxt_busy = ((busy_ff & ~done_w) | set_w) & ~kill_w;
  wire [3:0] nxt_ld = ((ld_ff | ldset_w) & ~done_w & ~set_w) & ~kill_w;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_ff <= 4'h0;
      ld_ff <= 4'h0;
    end else if (ce_i) begin
      busy_ff <= hold_w ? 4'h0 : nxt_busy;
      ld_ff <= hold_w ? 4'h0 : nxt_ld;
    end
  end

  // ----------------------------------------------------------------
  // busy read-back
  // ----------------------------------------------------------------
  wire rd_act_w = ~pin_s[fcavp_pkg::PIN_CS] & ~pin_s[fcavp_pkg::PIN_RD]
    & ~hold_w;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
    end else if (ce_i) begin
      data_o <= rd_act_w ? {4'h0, busy_ff} : 8'h00;
      data_oe_o <= rd_act_w;
    end
  end

  // ----------------------------------------------------------------
  // sample tick
  // ----------------------------------------------------------------
  logic [14:0] tcnt_ff;
  wire [14:0] per_w = pin_s[fcavp_pkg::PIN_RATE]
    ? 15'(PER_HI - 1) : 15'(PER_LO - 1);
  // >= so a rate change mid-period never overruns
  wire tick_w = tcnt_ff >= per_w;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tcnt_ff <= 15'h0000;
    end else if (ce_i) begin
      tcnt_ff <= (tick_w || hold_w) ? 15'h0000 : tcnt_ff + 15'h0001;
    end
  end

  // ----------------------------------------------------------------
  // channel sequencer
  // ----------------------------------------------------------------
  fcavp_pkg::fcavp_state_t st_ff;
  logic [1:0] ch_ff;
  logic [2:0] tix_ff;
  logic [4:0] wcnt_ff;
  logic [17:0] cur_ff [4];
  logic [17:0] stop_ff [4];
  logic [7:0] byte_ff [4];
  logic [3:0] hi_ff;
  logic signed [11:0] pred_ff [4];
  logic [5:0] idx_ff [4];
  logic signed [11:0] dec_pred_w;
  logic [5:0] dec_idx_w;

  wire cbusy_w = busy_ff[ch_ff];
  wire cld_w = ld_ff[ch_ff];
  wire chi_w = hi_ff[ch_ff];
  wire [3:0] chbit_w = 4'h1 << ch_ff;
  wire rd_ok_w = (st_ff == fcavp_pkg::S_RD) && (wcnt_ff == 5'h00);
  wire last_tb_w = tix_ff == fcavp_pkg::TBL_LAST;
  wire at_end_w = cur_ff[ch_ff] == stop_ff[ch_ff];
  wire last_ch_w = ch_ff == 2'h3;
  wire [1:0] pos_w = (tix_ff >= fcavp_pkg::TBL_STOP)
    ? 2'(tix_ff - fcavp_pkg::TBL_STOP) : tix_ff[1:0];
  wire [3:0] nib_w = chi_w ? byte_ff[ch_ff][7:4]
    : byte_ff[ch_ff][3:0];

  assign ldset_w = (rd_ok_w && !cld_w && last_tb_w) ? chbit_w : 4'h0;
  // the channel ends after the low nibble of the stop byte
  assign done_w = (st_ff == fcavp_pkg::S_DEC && !chi_w && at_end_w)
    ? chbit_w : 4'h0;

  // places one table byte into an 18-bit address, high byte first
  function automatic logic [17:0] put_byte(input logic [17:0] a,
                                          input logic [1:0] pos,
                                          input logic [7:0] d);
    unique case (pos)
      2'h0: put_byte = {d[1:0], a[15:0]};
      2'h1: put_byte = {a[17:16], d, a[7:0]};
      default: put_byte = {a[17:8], d};
    endcase
  endfunction

  fcavp_adpcm u_adpcm (
    .pred_i(pred_ff[ch_ff]),
    .idx_i(idx_ff[ch_ff]),
    .nib_i(nib_w),
    .pred_o(dec_pred_w),
    .idx_o(dec_idx_w)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= fcavp_pkg::S_IDLE;
      ch_ff <= 2'h0;
      tix_ff <= 3'h0;
      wcnt_ff <= 5'h00;
      rom_addr_o <= 18'h0_0000;
    end else if (ce_i) begin
      if (hold_w) begin
        st_ff <= fcavp_pkg::S_IDLE;
      end else if (set_w[ch_ff] && (st_ff == fcavp_pkg::S_CHAN
        || st_ff == fcavp_pkg::S_RD)) begin
        // restart under way: drop the read, reload the table
        st_ff <= fcavp_pkg::S_CHAN;
      end else begin
        unique case (st_ff)
          fcavp_pkg::S_IDLE: begin
            if (tick_w) begin
              ch_ff <= 2'h0;
              st_ff <= fcavp_pkg::S_CHAN;
            end
          end
          fcavp_pkg::S_CHAN: begin
            if (cbusy_w && !cld_w) begin
              rom_addr_o <= {8'h00, phr_ff[ch_ff], 3'h0};
              tix_ff <= 3'h0;
              wcnt_ff <= fcavp_pkg::ROM_WAIT;
              st_ff <= fcavp_pkg::S_RD;
            end else if (cbusy_w && chi_w) begin
              rom_addr_o <= cur_ff[ch_ff];
              wcnt_ff <= fcavp_pkg::ROM_WAIT;
              st_ff <= fcavp_pkg::S_RD;
            end else if (cbusy_w) begin
              st_ff <= fcavp_pkg::S_DEC;
            end else begin
              ch_ff <= ch_ff + 2'h1;
              st_ff <= last_ch_w ? fcavp_pkg::S_MIX : fcavp_pkg::S_CHAN;
            end
          end
          fcavp_pkg::S_RD: begin
            if (wcnt_ff != 5'h00) begin
              wcnt_ff <= wcnt_ff - 5'h01;
            end else if (cld_w) begin
              st_ff <= fcavp_pkg::S_DEC;
            end else if (last_tb_w) begin
              // bytes 6 and 7 of the entry are never fetched
              ch_ff <= ch_ff + 2'h1;
              st_ff <= last_ch_w ? fcavp_pkg::S_MIX : fcavp_pkg::S_CHAN;
            end else begin
              tix_ff <= tix_ff + 3'h1;
              rom_addr_o <= rom_addr_o + 18'h0_0001;
              wcnt_ff <= fcavp_pkg::ROM_WAIT;
            end
          end
          fcavp_pkg::S_DEC: begin
            ch_ff <= ch_ff + 2'h1;
            st_ff <= last_ch_w ? fcavp_pkg::S_MIX : fcavp_pkg::S_CHAN;
          end
          fcavp_pkg::S_MIX: begin
            st_ff <= fcavp_pkg::S_IDLE;
          end
          default: begin
            st_ff <= fcavp_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel storage
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      wire here_w = ce_i && !hold_w && (ch_ff == 2'(g));
      wire tb_w = here_w && rd_ok_w && !cld_w;
      wire dec_w = here_w && (st_ff == fcavp_pkg::S_DEC);
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          cur_ff[g] <= 18'h0_0000;
          stop_ff[g] <= 18'h0_0000;
          byte_ff[g] <= 8'h00;
          hi_ff[g] <= 1'b1;
          pred_ff[g] <= 12'sh000;
          idx_ff[g] <= 6'h00;
        end else if (tb_w && tix_ff < fcavp_pkg::TBL_STOP) begin
          cur_ff[g] <= put_byte(cur_ff[g], pos_w, rom_s);
        end else if (tb_w) begin
          stop_ff[g] <= put_byte(stop_ff[g], pos_w, rom_s);
          if (last_tb_w) begin
            pred_ff[g] <= 12'sh000;
            idx_ff[g] <= 6'h00;
            hi_ff[g] <= 1'b1;
          end
        end else if (here_w && rd_ok_w) begin
          byte_ff[g] <= rom_s;
        end else if (dec_w) begin
          pred_ff[g] <= dec_pred_w;
          idx_ff[g] <= dec_idx_w;
          hi_ff[g] <= ~hi_ff[g];
          if (!hi_ff[g] && !at_end_w) begin
            cur_ff[g] <= cur_ff[g] + 18'h0_0001;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // mixer
  // ----------------------------------------------------------------
  logic signed [12:0] sc_w [4];
  logic signed [21:0] prod_w [4];

  generate
    for (g = 0; g < 4; g++) begin : g_mix
      assign prod_w[g] = 22'(pred_ff[g]
        * signed'({1'b0, fcavp_pkg::fcavp_gain(att_ff[g])}));
      assign sc_w[g] = (busy_ff[g] && ld_ff[g])
        ? prod_w[g][20:8] : 13'sh0000;
    end
  endgenerate

  wire signed [14:0] sum_w = 15'(sc_w[0]) + 15'(sc_w[1])
    + 15'(sc_w[2]) + 15'(sc_w[3]);
  wire signed [11:0] sat_w = (sum_w > 15'sh07FF) ? 12'sh7FF
    : (sum_w < -15'sh0800) ? -12'sh800 : sum_w[11:0];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      voice_out_o <= fcavp_pkg::VOICE_MID;
    end else if (ce_i) begin
      if (hold_w) begin
        voice_out_o <= fcavp_pkg::VOICE_MID;
      end else if (st_ff == fcavp_pkg::S_MIX) begin
        // offset binary: midscale is silence
        voice_out_o <= {~sat_w[11], sat_w[10:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_second;
    ce_i && !hold_w && start_w;
  endsequence

  a_start_sel: assert property (s_second |=>
    (busy_ff & $past(sel_w)) == $past(sel_w)
      && (ld_ff & $past(sel_w)) == 4'h0)
    else $error("start did not mark its channel busy");
  a_first_quiet: assert property ((ce_i && first_w && !hold_w) |=>
    busy_ff == $past(busy_ff & ~done_w))
    else $error("first byte alone changed busy flags");
  a_stop_now: assert property ((ce_i && stop_w && !hold_w) |=>
    (busy_ff & $past(d_w[6:3])) == 4'h0)
    else $error("stopped channel still busy");
  a_read_flags: assert property ((ce_i && rd_act_w) |=>
    data_oe_o && data_o == {4'h0, $past(busy_ff)})
    else $error("busy read-back wrong");
  a_hold_clear: assert property ((ce_i && hold_w) |=>
    busy_ff == 4'h0 && st_ff == fcavp_pkg::S_IDLE)
    else $error("reset pin did not suspend");
  a_table_addr: assert property ((st_ff == fcavp_pkg::S_RD && !cld_w) |->
    rom_addr_o == {8'h00, phr_ff[ch_ff], tix_ff})
    else $error("table address malformed");
  a_rom_wait: assert property ($rose(st_ff == fcavp_pkg::S_RD) |->
    wcnt_ff == fcavp_pkg::ROM_WAIT)
    else $error("rom wait not loaded");
  a_nib_order: assert property ((ce_i && !hold_w
    && st_ff == fcavp_pkg::S_DEC && chi_w) |=> !hi_ff[$past(ch_ff)])
    else $error("nibble order broken");
  a_tick_wrap: assert property ((ce_i && tick_w) |=>
    tcnt_ff == 15'h0000 ##1 tcnt_ff <= 15'(PER_LO - 1))
    else $error("sample period counter overran");
  a_mid_idle: assert property ((ce_i && !hold_w && busy_ff == 4'h0
    && st_ff == fcavp_pkg::S_MIX) |=> voice_out_o == fcavp_pkg::VOICE_MID)
    else $error("silent output not midscale");

endmodule

// [dv/fcavp_host.sv]
`timescale 1ns/100ps
module fcavp_host (
  // clock
  input wire logic clk_i,
  // command bus
  input wire logic [7:0] bus_i,
  output logic cs_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [7:0] data_o
);
  initial begin
    cs_n_o = 1'h1;
    wr_n_o = 1'h1;
    rd_n_o = 1'h1;
    data_o = 8'h00;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // select and data held four edges either side of the write rise
  task automatic put(input logic [7:0] b);
    @(posedge clk_i);
    cs_n_o <= 1'h0;
    data_o <= b;
    wr_n_o <= 1'h0;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'h1;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'h1;
    data_o <= ~b; // released bus must not keep a stale copy
    repeat (4) @(posedge clk_i);
  endtask

  // caller keeps p nonzero
  task automatic start(input logic [6:0] p, input logic [1:0] ch,
                       input logic [3:0] att);
    put({1'h1, p});
    put({4'h1 << ch, att});
    repeat (16) @(posedge clk_i);
  endtask

  task automatic halt(input logic [3:0] m);
    put({1'h0, m, 3'h5});
  endtask

  task automatic peek(output logic [7:0] v);
    @(posedge clk_i);
    cs_n_o <= 1'h0;
    rd_n_o <= 1'h0;
    repeat (6) @(posedge clk_i);
    v = bus_i;
    rd_n_o <= 1'h1;
    cs_n_o <= 1'h1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// [dv/fcavp_top_test.sv]
`timescale 1ns/100ps
module fcavp_top_test;
  localparam int PH = 200;
  localparam int PL = 256;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic reset_n = 1'h1;
  logic rate_sel = 1'h1;
  logic cs_n, wr_n, rd_n, data_oe;
  logic [7:0] host_d, bus, dout, rom_data;
  logic [17:0] rom_addr;
  logic [11:0] voice;
  logic [31:0] rnd = 32'h0001_32DD;
  logic [17:0] bad_a = 18'h3_FFFF;
  logic hit_bad = 1'h0;
  logic [17:0] tbl_a = 18'h3_FFFF;
  logic hit_tbl = 1'h0;
  logic moved = 1'h0;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  // ----------------------------------------------------------------
  // sample rom: table below 400h, pattern data above
  // ----------------------------------------------------------------
  function automatic logic [17:0] st_addr(input logic [6:0] p);
    st_addr = {p[1:0], p, 9'h000};
  endfunction
  function automatic logic [17:0] sp_addr(input logic [6:0] p);
    sp_addr = st_addr(p) + ((p[6:3] == 4'h0) ? 18'h0_0001 : 18'h0_00C8);
  endfunction
  function automatic logic [7:0] rom_byte(input logic [17:0] a);
    logic [17:0] x;
    x = (a[2:0] < 3'h3) ? st_addr(a[9:3]) : sp_addr(a[9:3]);
    if (a[17:10] != 8'h00) begin
      rom_byte = a[7:0] ^ 8'h5A;
    end else begin
      case (a[2:0])
        3'h0, 3'h3: rom_byte = {6'h00, x[17:16]};
        3'h1, 3'h4: rom_byte = x[15:8];
        3'h2, 3'h5: rom_byte = x[7:0];
        default: rom_byte = 8'hA5;
      endcase
    end
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  assign rom_data = rom_byte(rom_addr);
  assign bus = data_oe ? dout : host_d;

  fcavp_top #(.PER_HI(PH), .PER_LO(PL)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .reset_n_i(reset_n),
    .rate_sel_i(rate_sel), .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
    .data_i(bus), .data_o(dout), .data_oe_o(data_oe),
    .rom_addr_o(rom_addr), .rom_data_i(rom_data), .voice_out_o(voice));
  fcavp_host host (.clk_i(clk_i), .bus_i(bus), .cs_n_o(cs_n),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .data_o(host_d));

  initial begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (rom_addr === bad_a) hit_bad <= 1'h1;
    if (rom_addr === tbl_a) hit_tbl <= 1'h1;
    if (voice !== 12'h800) moved <= 1'h1;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t seen %0h want %0h", $time, seen, want);
    end
  endtask
  task automatic busy_is(input logic [3:0] b);
    logic [7:0] v;
    host.peek(v);
    check(v, {4'h0, b});
  endtask
  task automatic find(input logic [17:0] a, input int lim, output int n);
    n = 0;
    while (rom_addr !== a && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d bad %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    logic [6:0] p;
    logic [1:0] ch;
    logic [3:0] ord;
    int n;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (10) @(posedge clk_i);
    check(voice, 12'h800);
    check(data_oe, 1'h0);
    $display("test reset done");
    p = 7'h05;
    bad_a <= sp_addr(p) + 18'h0_0001;
    tbl_a <= {8'h00, p, 3'h0};
    host.put({1'h1, p});
    busy_is(4'h0);
    host.put({4'h1, 4'h0});
    busy_is(4'h1);
    find(st_addr(p), 1000, n);
    check(n < 1000, 1'h1);
    check(hit_tbl, 1'h1);
    busy_is(4'h1);
    find(sp_addr(p), 1000, n);
    check(n < 1000, 1'h1);
    repeat (3 * PH) @(posedge clk_i);
    busy_is(4'h0);
    check(hit_bad, 1'h0);
    $display("test phrase done");
    p = 7'h40;
    host.start(p, 2'h1, 4'h0);
    find(st_addr(p) + 18'h0_0001, 2000, n);
    find(st_addr(p) + 18'h0_0002, 2000, n);
    check(n, 2 * PH);
    rate_sel <= 1'h0;
    find(st_addr(p) + 18'h0_0004, 3000, n);
    find(st_addr(p) + 18'h0_0005, 3000, n);
    check(n, 2 * PL);
    rate_sel <= 1'h1;
    $display("test rate done");
    ord = 4'h2;
    for (int a = 0; a < 9; a++) begin
      host.start(7'h10, 2'(a), 4'(a));
      ord = ord | (4'h1 << a[1:0]);
      busy_is(ord);
    end
    host.halt(4'hF);
    busy_is(4'h0);
    repeat (2 * PH) @(posedge clk_i);
    check(voice, 12'h800);
    moved <= 1'h0;
    $display("test gain done");
    ord = 4'h0;
    while (ord != 4'hF) begin
      rnd = lfsr(rnd);
      ch = rnd[1:0];
      if (!ord[ch]) begin
        p = 7'h08 + 7'(rnd[9:2] % 120);
        host.start(p, ch, 4'(rnd[13:10] % 9));
        ord[ch] = 1'h1;
        busy_is(ord);
      end
    end
    repeat (4 * PH) @(posedge clk_i);
    check(moved, 1'h1);
    host.halt(4'h5);
    busy_is(4'hA);
    host.halt(4'hA);
    busy_is(4'h0);
    repeat (2 * PH) @(posedge clk_i);
    check(voice, 12'h800);
    $display("test channels done");
    host.start(7'h20, 2'h3, 4'h0);
    repeat (4 * PH) @(posedge clk_i);
    reset_n <= 1'h0;
    host.start(7'h21, 2'h0, 4'h0);
    check(voice, 12'h800);
    reset_n <= 1'h1;
    repeat (6) @(posedge clk_i);
    busy_is(4'h0);
    $display("test suspend done");
    stop_test();
  end
endmodule
